//--- tb/adc_conversion_control_props.sv
// Purpose: Port-level checks of the converter control block
// Assumes: APB writes land at the access edge
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
module adc_conversion_control_props
    import adc_conversion_control_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic external_start_pin,
    input wire logic aux_timer_overflow,
    input wire logic timer2_overflow,
    input wire logic [11:0] sample_data,
    input wire analog_ctl_t analog_ctl,
    input wire logic irq
);
    logic [7:0] ctl_r;
    wire wr = psel && penable && pwrite;
    wire rd = psel && penable && !pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctl_r <= 8'h00;
        else if (wr && paddr == 8'he8) ctl_r <= pwdata[7:0];
    end
    ////////////////////////////////////////////////////////////////
    a_power_follows: assert property (wr && paddr == 8'he8 |=>
        analog_ctl.power_on == $past(pwdata[7])) else $error("power bit not taken");
    a_power_holds: assert property (!(wr && paddr == 8'he8) |=>
        $stable(analog_ctl.power_on)) else $error("power changed without write");
    a_off_not_busy: assert property (rd && paddr == 8'he8 && !$past(analog_ctl.power_on)
        |-> !prdata[4]) else $error("busy while powered down");
    a_ctl_readback: assert property (rd && paddr == 8'he8 |->
        prdata[7:6] == ctl_r[7:6] && prdata[2:0] == ctl_r[2:0]) else $error("control readback");
    a_sensor_follows: assert property (wr && paddr == 8'hf0 |=>
        analog_ctl.sensor_on == $past(pwdata[2])) else $error("sensor enable not taken");
    a_chan_follows: assert property (wr && paddr == 8'hec |=>
        analog_ctl.channel == $past(pwdata[4:0])) else $error("channel not taken");
    a_sensor_route: assert property (analog_ctl.sensor_routed ==
        (analog_ctl.channel == 5'h10)) else $error("sensor routing wrong");
    a_irq_masked: assert property (wr && paddr == 8'he0 && pwdata[1:0] == 2'b00
        |=> !irq [*2]) else $error("irq with all masked");
    c_sw_start: cover property (wr && paddr == 8'he8 && pwdata[4]);
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
endmodule : adc_conversion_control_props

bind adc_conversion_control adc_conversion_control_props adc_conversion_control_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .external_start_pin(external_start_pin), .aux_timer_overflow(aux_timer_overflow),
    .timer2_overflow(timer2_overflow), .sample_data(sample_data),
    .analog_ctl(analog_ctl), .irq(irq));

//--- tb/test_adc_conversion_control.sv
// Purpose: Self-checking bench of the converter control block
// Assumes: Zero-wait APB, 16-cycle conversions
// Notes: Random thresholds and samples from a bench LFSR
`timescale 1ns/1ps
module test_adc_conversion_control;
    import adc_conversion_control_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, lj;
    logic ext_pin, aux_ov, t2_ov;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [11:0] sample;
    logic [15:0] rnd, u, l, r;
    analog_ctl_t actl;
    int num_errors = 0;
    int cmp_count = 0;
    adc_conversion_control adc_conversion_control_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_start_pin(ext_pin),
        .aux_timer_overflow(aux_ov), .timer2_overflow(t2_ov), .sample_data(sample),
        .analog_ctl(actl), .irq(irq));
    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : nxt
    function automatic logic win(input logic [15:0] u, input logic [15:0] l, input logic [15:0] r);
        return (u < l) ? (r > u && r < l) : (r > u || r < l);
    endfunction : win
    task automatic end_of_test;
        if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        end_of_test;
    end
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        ext_pin = 0; aux_ov = 0; t2_ov = 0; sample = 12'h5a3; rnd = 16'ha60e;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, 8'he8, 0); check(q, 32'h0);
        for (int s = 0; s < 4; s++) begin
            apb(1, 8'he8, 32'h90 | s);
            apb(0, 8'he8, 0); check(q[4], s == 0);
            @(posedge pclk);
            aux_ov <= (s == 1); t2_ov <= (s == 3); ext_pin <= (s == 2);
            @(posedge pclk);
            aux_ov <= 1'b0; t2_ov <= 1'b0;
            repeat (3) @(posedge pclk);
            ext_pin <= 1'b0;
            apb(0, 8'he8, 0); check(q[5:4], 2'b01);
            repeat (18) @(posedge pclk);
            apb(0, 8'he8, 0); check(q[5:4], 2'b10);
        end
        apb(1, 8'he0, 3);
        for (int i = 0; i < 6; i++) begin
            rnd = nxt(rnd); u = rnd[11:0]; rnd = nxt(rnd); l = rnd[11:0]; rnd = nxt(rnd);
            lj = rnd[14];
            if (i == 0) begin u = 16'h100; l = 16'h200; lj = 0; rnd[11:0] = 12'h200; end
            if (i == 1) begin u = 16'h200; l = 16'h100; lj = 0; rnd[11:0] = 12'h201; end
            sample <= rnd[11:0];
            apb(1, 8'hf8, u); apb(1, 8'hfc, l);
            apb(1, 8'he8, 32'h90 | {29'h0, lj, 2'b00});
            repeat (18) @(posedge pclk);
            r = lj ? {sample, 4'h0} : {4'h0, sample};
            apb(0, 8'hf4, 0); check(q, r);
            apb(0, 8'hdc, 0); check(q, {win(u, l, r), 1'b1});
            @(negedge pclk); check(irq, 1);
            apb(1, 8'hdc, 3); @(negedge pclk); check(irq, 0);
            apb(0, 8'he8, 0); check(q[5:3], 0);
        end
        apb(1, 8'hd8, 1); apb(1, 8'he8, 32'hd0);
        repeat (70) @(posedge pclk);
        @(negedge pclk); check(irq, 1);
        apb(1, 8'he0, 0); @(negedge pclk); check(irq, 0);
        apb(1, 8'hf4, 0); apb(0, 8'hf4, 0); check(q, {sample, 2'b00});
        apb(1, 8'he8, 32'h90); apb(1, 8'he8, 0);
        apb(0, 8'he8, 0); check(q, 0); check(actl.power_on, 0);
        apb(1, 8'hec, 32'h10); apb(1, 8'hf0, 4); @(negedge pclk); check(actl, 8'h61);
        apb(1, 8'hf0, 0); apb(1, 8'hec, 32'h0f); @(negedge pclk); check(actl, 8'h1e);
        apb(1, 8'h04, 32'hffff); apb(0, 8'h04, 0); check(q, 0); check(err, 1);
        end_of_test;
    end
endmodule : test_adc_conversion_control

//--- verilog/adc_conversion_control.sv
// Purpose: Control and status logic of a 12-bit successive-approximation converter
// Assumes: APB slave on pclk, analog sample word arrives asynchronously
// Notes: Zero wait states; read data is captured in the setup cycle
//
// Function
// (R1) The enable bit powers the converter down when zero and lets it accept starts when one.
// (R2) The burst bit turns on burst operation of repeated conversions per start.
// (R3) The done flag sets when a conversion finishes and reads zero until the next finish; here it stays set until software clears it.
// (R4) The busy bit reads one exactly while a conversion is in progress.
// (R5) Writing one to the busy bit starts a conversion only with the software source selected.
// (R6) The window flag sets on a window match and stays set until software clears it.
// (R7) The justify bit places the result right-justified when zero, left-justified when one.
// (R8) Firmware must not choose left-justified results with a repeat count above one.
// (R9) The start-source field picks software, auxiliary timer, external pin or timer 2 trigger.
// (R10) The sensor is routed to the positive input whenever the channel field selects it.
// (R11) The sensor-enable bit switches the temperature sensor on or off.
// (R12) The window flag rises for a result inside or outside the thresholds by their order.
// (R13) A conversion end updates result, clears busy and sets done in one cycle.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
`include "adc_conversion_control_map.svh"

module adc_conversion_control (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_start_pin,
    input wire logic aux_timer_overflow,
    input wire logic timer2_overflow,
    input wire logic [11:0] sample_data,
    output adc_conversion_control_pkg::analog_ctl_t analog_ctl,
    output logic irq
);
    import adc_conversion_control_pkg::*;

    state_t s_r;
    state_t s_nxt;
    logic wr_en;
    logic rd_setup;
    logic trig;
    logic start;
    logic [15:0] sum;
    logic [15:0] new_result;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [4:0] reps_of(input logic [1:0] code);
        case (code)
            2'b00: reps_of = 5'd1;
            2'b01: reps_of = 5'd4;
            2'b10: reps_of = 5'd8;
            default: reps_of = 5'd16;
        endcase
    endfunction : reps_of

    function automatic logic [15:0] justify(input logic [15:0] acc, input logic left);
        justify = left ? {acc[11:0], 4'h0} : acc;
    endfunction : justify

    // Ordered thresholds give an inside window, reversed ones an outside window
    function automatic logic window_hit(input logic [15:0] r, input logic [15:0] gt,
                                        input logic [15:0] lt);
        if (gt < lt) begin
            window_hit = (r > gt) && (r < lt);
        end else begin
            window_hit = (r > gt) || (r < lt);
        end
    endfunction : window_hit

    function automatic logic mapped(input logic [`ADDR_W-1:0] a);
        case (a)
            `OFF_ACCUM_CONFIG, `OFF_IRQ_STATUS, `OFF_IRQ_MASK, `OFF_ADC_CONTROL,
            `OFF_INPUT_MUX, `OFF_REFERENCE_CONTROL, `OFF_RESULT_WORD,
            `OFF_UPPER_THRESHOLD, `OFF_LOWER_THRESHOLD: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    endfunction : mapped

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake

    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata = s_r.prdata;
    assign wr_en = psel && penable && pwrite && mapped(paddr);
    assign rd_setup = psel && !penable && !pwrite;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        s_nxt = s_r;
        trig = 1'b0;
        start = 1'b0;
        sum = s_r.accum + {4'h0, s_r.data_sync1};
        new_result = justify(sum, s_r.adc_control[`BIT_LEFT_JUSTIFY]); // R7

        s_nxt.ext_sync = {s_r.ext_sync[0], external_start_pin};
        s_nxt.ext_prev = s_r.ext_sync[1];
        s_nxt.data_sync0 = sample_data;
        s_nxt.data_sync1 = s_r.data_sync0;

        // Register writes; hardware sets below take priority over clears
        if (wr_en) begin
            case (paddr)
                `OFF_ADC_CONTROL: begin
                    s_nxt.adc_control[7:6] = pwdata[7:6]; // R1 R2
                    s_nxt.adc_control[`BIT_CONVERSION_DONE] =
                        s_r.adc_control[`BIT_CONVERSION_DONE] & pwdata[5];
                    s_nxt.adc_control[`BIT_WINDOW_MATCH] =
                        s_r.adc_control[`BIT_WINDOW_MATCH] & pwdata[3]; // R6
                    s_nxt.adc_control[2:0] = pwdata[2:0]; // R7 R9
                end
                `OFF_IRQ_STATUS: begin
                    if (pwdata[`IRQ_BIT_DONE]) begin
                        s_nxt.adc_control[`BIT_CONVERSION_DONE] = 1'b0;
                    end
                    if (pwdata[`IRQ_BIT_WINDOW]) begin
                        s_nxt.adc_control[`BIT_WINDOW_MATCH] = 1'b0; // R6
                    end
                end
                `OFF_IRQ_MASK: s_nxt.irq_mask = pwdata[1:0];
                `OFF_ACCUM_CONFIG: s_nxt.repeat_code = pwdata[1:0];
                `OFF_INPUT_MUX: s_nxt.input_channel_select = pwdata[4:0];
                `OFF_REFERENCE_CONTROL:
                    s_nxt.temp_sensor_enable = pwdata[`BIT_TEMP_SENSOR_ENABLE]; // R11
                `OFF_UPPER_THRESHOLD: s_nxt.upper_threshold = pwdata[15:0];
                `OFF_LOWER_THRESHOLD: s_nxt.lower_threshold = pwdata[15:0];
                default: ;
            endcase
        end

        // Trigger selection uses the control value in force after this write
        case (s_nxt.adc_control[1:0]) // R9
            `SRC_SOFTWARE: trig = wr_en && (paddr == `OFF_ADC_CONTROL)
                                && pwdata[`BIT_CONVERSION_BUSY]; // R5
            `SRC_AUX_TIMER: trig = aux_timer_overflow;
            `SRC_EXT_PIN: trig = s_r.ext_sync[1] && !s_r.ext_prev;
            default: trig = timer2_overflow;
        endcase
        start = trig && s_nxt.adc_control[`BIT_CONVERTER_ENABLE]; // R1

        case (s_r.state)
            st_idle: begin
                if (start) begin
                    s_nxt.state = st_convert;
                    s_nxt.cycle_cnt = `CONV_CYCLES - 5'd1;
                    s_nxt.reps_left = s_nxt.adc_control[`BIT_BURST_ENABLE] ?
                                      reps_of(s_nxt.repeat_code) : 5'd1; // R2
                    s_nxt.accum = 16'h0000;
                    s_nxt.adc_control[`BIT_CONVERSION_BUSY] = 1'b1; // R4
                end
            end
            st_convert: begin
                if (!s_nxt.adc_control[`BIT_CONVERTER_ENABLE]) begin
                    s_nxt.state = st_idle; // R1
                    s_nxt.adc_control[`BIT_CONVERSION_BUSY] = 1'b0; // R4
                end else if (s_r.cycle_cnt != 5'd0) begin
                    s_nxt.cycle_cnt = s_r.cycle_cnt - 5'd1;
                end else if (s_r.reps_left != 5'd1) begin
                    s_nxt.accum = sum;
                    s_nxt.reps_left = s_r.reps_left - 5'd1;
                    s_nxt.cycle_cnt = `CONV_CYCLES - 5'd1;
                end else begin
                    s_nxt.state = st_idle;
                    s_nxt.result_word = new_result; // R13
                    s_nxt.adc_control[`BIT_CONVERSION_BUSY] = 1'b0; // R4 R13
                    s_nxt.adc_control[`BIT_CONVERSION_DONE] = 1'b1; // R3 R13
                    if (window_hit(new_result, s_r.upper_threshold, s_r.lower_threshold)) begin
                        s_nxt.adc_control[`BIT_WINDOW_MATCH] = 1'b1; // R6 R12
                    end
                end
            end
            default: s_nxt.state = st_idle;
        endcase

        // Read data captured in setup so it stands through the access phase
        if (rd_setup) begin
            case (paddr)
                `OFF_ADC_CONTROL: s_nxt.prdata = {24'h0, s_r.adc_control}; // R3 R4
                `OFF_IRQ_STATUS: s_nxt.prdata = {30'h0,
                    s_r.adc_control[`BIT_WINDOW_MATCH], s_r.adc_control[`BIT_CONVERSION_DONE]};
                `OFF_IRQ_MASK: s_nxt.prdata = {30'h0, s_r.irq_mask};
                `OFF_ACCUM_CONFIG: s_nxt.prdata = {30'h0, s_r.repeat_code};
                `OFF_INPUT_MUX: s_nxt.prdata = {27'h0, s_r.input_channel_select};
                `OFF_REFERENCE_CONTROL: s_nxt.prdata = {29'h0, s_r.temp_sensor_enable, 2'b00};
                `OFF_RESULT_WORD: s_nxt.prdata = {16'h0, s_r.result_word};
                `OFF_UPPER_THRESHOLD: s_nxt.prdata = {16'h0, s_r.upper_threshold};
                `OFF_LOWER_THRESHOLD: s_nxt.prdata = {16'h0, s_r.lower_threshold};
                default: s_nxt.prdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Analog side and interrupt

    always_comb begin
        analog_ctl.power_on = s_r.adc_control[`BIT_CONVERTER_ENABLE]; // R1
        analog_ctl.sensor_on = s_r.temp_sensor_enable; // R11
        analog_ctl.channel = s_r.input_channel_select;
        analog_ctl.sensor_routed = (s_r.input_channel_select == `TEMP_SENSOR_CHANNEL); // R10
    end

    assign irq = |({s_r.adc_control[`BIT_WINDOW_MATCH],
                    s_r.adc_control[`BIT_CONVERSION_DONE]} & s_r.irq_mask);

endmodule : adc_conversion_control

//--- verilog/adc_conversion_control_map.svh
// Purpose: Register map, field positions, reset values and timing counts
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: Included by the converter control block only
`ifndef ADC_CONVERSION_CONTROL_MAP_SVH
`define ADC_CONVERSION_CONTROL_MAP_SVH

`define ADDR_W 8
`define OFF_ACCUM_CONFIG 8'hd8
`define OFF_IRQ_STATUS 8'hdc
`define OFF_IRQ_MASK 8'he0
`define OFF_ADC_CONTROL 8'he8
`define OFF_INPUT_MUX 8'hec
`define OFF_REFERENCE_CONTROL 8'hf0
`define OFF_RESULT_WORD 8'hf4
`define OFF_UPPER_THRESHOLD 8'hf8
`define OFF_LOWER_THRESHOLD 8'hfc

`define ADC_CONTROL_RESET 8'h00
`define BIT_CONVERTER_ENABLE 7
`define BIT_BURST_ENABLE 6
`define BIT_CONVERSION_DONE 5
`define BIT_CONVERSION_BUSY 4
`define BIT_WINDOW_MATCH 3
`define BIT_LEFT_JUSTIFY 2
`define BIT_TEMP_SENSOR_ENABLE 2
`define IRQ_BIT_DONE 0
`define IRQ_BIT_WINDOW 1

`define SRC_SOFTWARE 2'b00
`define SRC_AUX_TIMER 2'b01
`define SRC_EXT_PIN 2'b10
`define SRC_TIMER2 2'b11

`define TEMP_SENSOR_CHANNEL 5'h10
`define CONV_CYCLES 5'd16

`endif

//--- verilog/adc_conversion_control_pkg.sv
// Purpose: Types shared by the converter control block and its bench
// Assumes: Map header supplies all numeric constants
// Notes: Whole module state is one packed struct
package adc_conversion_control_pkg;

    typedef enum logic {st_idle, st_convert} conv_state_t;

    typedef struct packed {
        logic power_on;
        logic sensor_on;
        logic [4:0] channel;
        logic sensor_routed;
    } analog_ctl_t;

    typedef struct packed {
        conv_state_t state;
        logic [7:0] adc_control;
        logic [4:0] input_channel_select;
        logic temp_sensor_enable;
        logic [1:0] repeat_code;
        logic [1:0] irq_mask;
        logic [15:0] upper_threshold;
        logic [15:0] lower_threshold;
        logic [15:0] result_word;
        logic [15:0] accum;
        logic [4:0] cycle_cnt;
        logic [4:0] reps_left;
        logic [1:0] ext_sync;
        logic ext_prev;
        logic [11:0] data_sync0;
        logic [11:0] data_sync1;
        logic [31:0] prdata;
    } state_t;

endpackage : adc_conversion_control_pkg
